// File: design/fsc_pkg.sv
// Purpose: shared constants for the flash command controller
// Assumes: word-wide flash bus, one core clock
// Notes:   command codes and status bit positions of the flash device
package fsc_pkg;
  localparam int          FSC_AW            = 24;
  localparam int          FSC_DW            = 16;
  localparam logic [15:0] FSC_CMD_LOCK_SETUP = 16'h0060;
  localparam logic [15:0] FSC_CMD_LOCK_SET   = 16'h0001;
  localparam logic [15:0] FSC_CMD_UNLOCK_ALL = 16'h00D0;
  localparam logic [15:0] FSC_CMD_READ_ID    = 16'h0090;
  localparam logic [15:0] FSC_CMD_READ_ARRAY = 16'h00FF;
  localparam logic [15:0] FSC_CMD_OTP_SETUP  = 16'h00C0;
  localparam logic [15:0] FSC_CMD_PIN_CFG    = 16'h00B8;
  localparam logic [15:0] FSC_CMD_READ_SR    = 16'h0070;
  localparam logic [15:0] FSC_CMD_CLEAR_SR   = 16'h0050;
  localparam logic [15:0] FSC_OTP_LOCK_DATA  = 16'hFFFD;
  localparam logic [23:0] FSC_LOCK_STAT_OFS  = 24'h000002;
  localparam logic [23:0] FSC_OTP_LOCK_ADDR  = 24'h000080;
  localparam logic [1:0]  FSC_CFG_LEVEL      = 2'h0;
  localparam logic [1:0]  FSC_CFG_PRG_ONLY   = 2'h2;
  localparam logic [5:0]  FSC_CFG_RSVD       = 6'h00;
  localparam int          FSC_SR_READY       = 7;
  localparam int          FSC_SR_ERASE_ERR   = 5;
  localparam int          FSC_SR_PROG_ERR    = 4;
  localparam int          FSC_SR_LOCKED_ERR  = 1;
  localparam int          FSC_CLK_PERIOD_PS  = 4000;
  localparam int          FSC_T_WE_NS        = 40;
  localparam int          FSC_T_RD_NS        = 100;
  localparam int          FSC_WE_CYC  = (FSC_T_WE_NS * 1000 + FSC_CLK_PERIOD_PS - 1) / FSC_CLK_PERIOD_PS;
  localparam int          FSC_RD_CYC  = (FSC_T_RD_NS * 1000 + FSC_CLK_PERIOD_PS - 1) / FSC_CLK_PERIOD_PS;
  localparam int          FSC_PULSE_NS       = 250;
  localparam int          FSC_PULSE_CYC = (FSC_PULSE_NS * 1000 + FSC_CLK_PERIOD_PS - 1) / FSC_CLK_PERIOD_PS;

  typedef enum logic [2:0] {
    FSC_OP_LOCK,
    FSC_OP_UNLOCK,
    FSC_OP_READ_LOCK,
    FSC_OP_PIN_CFG,
    FSC_OP_OTP_READ,
    FSC_OP_OTP_PROG,
    FSC_OP_CLEAR_SR
  } fsc_op_e;
endpackage : fsc_pkg

// File: design/fsc_bus_if.sv
`timescale 1ns/1ps
// Purpose: one bus cycle request between sequencer and cycle engine
// Assumes: single clock
// Notes:   start is a one-cycle pulse, done likewise
interface fsc_bus_if;
  logic                        start;
  logic                        wr;
  logic [fsc_pkg::FSC_AW-1:0]  addr;
  logic [fsc_pkg::FSC_DW-1:0]  wdata;
  logic [fsc_pkg::FSC_DW-1:0]  rdata;
  logic                        done;
  modport seq (output start, output wr, output addr, output wdata, input rdata, input done);
  modport eng (input start, input wr, input addr, input wdata, output rdata, output done);
endinterface : fsc_bus_if

// File: design/fsc_cycle_eng.sv
`timescale 1ns/1ps
// Purpose: one asynchronous flash bus cycle, write or read
// Assumes: flash pins registered, data in sampled synchronously
// Notes:   strobe held a rounded-up number of core cycles
module fsc_cycle_eng #(
  parameter int WE_CYC = fsc_pkg::FSC_WE_CYC,
  parameter int RD_CYC = fsc_pkg::FSC_RD_CYC
) (
  input  wire logic                       i_core_clk,
  input  wire logic                       i_rst,
  fsc_bus_if.eng                          bus,
  input  wire logic [fsc_pkg::FSC_DW-1:0] i_dq,
  output logic      [fsc_pkg::FSC_AW-1:0] o_addr,
  output logic      [fsc_pkg::FSC_DW-1:0] o_dq,
  output logic                            o_dq_oe,
  output logic                            o_ce_n,
  output logic                            o_we_n,
  output logic                            o_oe_n
);
  import fsc_pkg::*;

  initial begin
    if (WE_CYC < 1 || RD_CYC < 1 || WE_CYC > 255 || RD_CYC > 255) $error("fsc_cycle_eng: bad strobe count");
  end

  typedef struct packed {
    logic          busy;
    logic          wr;
    logic [7:0]    cnt;
    logic [FSC_AW-1:0] addr;
    logic [FSC_DW-1:0] dq;
    logic          dq_oe;
    logic          ce_n;
    logic          we_n;
    logic          oe_n;
    logic [FSC_DW-1:0] rdata;
    logic          done;
  } fsc_eng_s;

  fsc_eng_s st_reg;
  fsc_eng_s st_next;

  always_comb begin
    st_next = st_reg;
    st_next.done = 1'b0;
    if (!st_reg.busy) begin
      if (bus.start) begin
        st_next.busy  = 1'b1;
        st_next.wr    = bus.wr;
        st_next.addr  = bus.addr;
        st_next.dq    = bus.wdata;
        st_next.dq_oe = bus.wr;
        st_next.ce_n  = 1'b0;
        st_next.we_n  = !bus.wr;
        st_next.oe_n  = bus.wr;
        st_next.cnt   = bus.wr ? 8'(WE_CYC) : 8'(RD_CYC);
      end
    end else if (st_reg.cnt > 8'h01) begin
      st_next.cnt = st_reg.cnt - 8'h01;
    end else begin
      // data sampled on the edge that raises the strobes; strobes and data drive all release in the same cycle
      if (!st_reg.wr) st_next.rdata = i_dq;
      st_next.busy  = 1'b0;
      st_next.ce_n  = 1'b1;
      st_next.we_n  = 1'b1;
      st_next.oe_n  = 1'b1;
      st_next.dq_oe = 1'b0;
      st_next.done  = 1'b1;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      st_reg      <= '0;
      st_reg.ce_n <= 1'b1;
      st_reg.we_n <= 1'b1;
      st_reg.oe_n <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign bus.rdata = st_reg.rdata;
  assign bus.done  = st_reg.done;
  assign o_addr    = st_reg.addr;
  assign o_dq      = st_reg.dq;
  assign o_dq_oe   = st_reg.dq_oe;
  assign o_ce_n    = st_reg.ce_n;
  assign o_we_n    = st_reg.we_n;
  assign o_oe_n    = st_reg.oe_n;
endmodule : fsc_cycle_eng

// File: design/fsc_ctrl.sv
`timescale 1ns/1ps
// Contract
// RULE1: code 00 means ready level on pin
// RULE2: code 01 pulses on erase completion
// RULE3: code 11 pulses on erase or program
// RULE4: host never sends code 10
// RULE5: completion pulse low about 250 ns
// RULE6: bad code sets both error flags
// RULE7: reserved config bits sent as zero
// RULE8: lock block: 0060h then 0001h in block
// RULE9: unlock all: 0060h then 00D0h anywhere
// RULE10: lock bits survive reset and power
// RULE11: locked blocks refuse program and erase
// RULE12: lock setup switches reads to status
// RULE13: completion shown by pin and ready flag
// RULE14: no lock ops while busy or suspended; code checks only the level-mode busy pin
// RULE15: low enable supply freezes lock bits
// RULE16: lock errors stay until status cleared
// RULE17: lock state at block base plus 02h
// RULE18: 128-bit array, two 64-bit halves
// RULE19: 0090h enters id read, 00FFh leaves
// RULE20: 00C0h then address and data write
// RULE21: out-of-range program sets program error
// RULE22: locked segment sets program and locked
// RULE23: lock user half with 0xFFFD at lock word
// RULE24: pin config 00B8h then code, when idle; idle checked only in level mode
// RULE25: default pin level low while busy
//
// Purpose: host-side sequencer for flash locking, status-pin setup and OTP access
// Assumes: word-wide device, pins sampled on core clock, status read polling
// Notes:   one operation at a time; o_busy high until the result is posted
module fsc_ctrl #(
  parameter int POLL_MAX = 4096
) (
  input  wire logic                       i_core_clk,
  input  wire logic                       i_rst,
  input  wire logic                       i_req,
  input  wire fsc_pkg::fsc_op_e           i_op,
  input  wire logic [fsc_pkg::FSC_AW-1:0] i_addr,
  input  wire logic [fsc_pkg::FSC_DW-1:0] i_wdata,
  input  wire logic [1:0]                 i_pin_code,
  input  wire logic                       i_status_output_pin,
  input  wire logic [fsc_pkg::FSC_DW-1:0] i_dq,
  output logic                            o_busy,
  output logic                            o_done,
  output logic      [fsc_pkg::FSC_DW-1:0] o_rdata,
  output logic      [7:0]                 o_status,
  output logic                            o_err,
  output logic                            o_refused,
  output logic                            o_evt_pulse,
  output logic      [fsc_pkg::FSC_AW-1:0] o_addr,
  output logic      [fsc_pkg::FSC_DW-1:0] o_dq,
  output logic                            o_dq_oe,
  output logic                            o_ce_n,
  output logic                            o_we_n,
  output logic                            o_oe_n
);
  import fsc_pkg::*;

  initial begin
    if (POLL_MAX < 1 || POLL_MAX > 65535) $error("fsc_ctrl: bad POLL_MAX");
  end

  typedef enum logic [3:0] {
    S_IDLE,
    S_W1,
    S_W2,
    S_RD,
    S_POLL,
    S_EXIT,
    S_CLEAR,
    S_FIN
  } fsc_state_e;

  typedef struct packed {
    fsc_state_e        state;
    fsc_op_e           op;
    logic [FSC_AW-1:0] addr;
    logic [FSC_DW-1:0] wdata;
    logic              issued;
    logic [15:0]       polls;
    logic              busy;
    logic              done;
    logic [FSC_DW-1:0] rdata;
    logic [7:0]        status;
    logic              err;
    logic              refused;
    logic              pin_d;
    logic [1:0]        pin_mode;
    logic              evt;
  } fsc_ctrl_s;

  fsc_ctrl_s   st_reg;
  fsc_ctrl_s   st_next;
  logic        b_start;
  logic        b_wr;
  logic [FSC_AW-1:0] b_addr;
  logic [FSC_DW-1:0] b_wdata;

  fsc_bus_if bus_if ();
  assign bus_if.start = b_start;
  assign bus_if.wr    = b_wr;
  assign bus_if.addr  = b_addr;
  assign bus_if.wdata = b_wdata;

  fsc_cycle_eng u_eng (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .bus        (bus_if),
    .i_dq       (i_dq),
    .o_addr     (o_addr),
    .o_dq       (o_dq),
    .o_dq_oe    (o_dq_oe),
    .o_ce_n     (o_ce_n),
    .o_we_n     (o_we_n),
    .o_oe_n     (o_oe_n)
  );

  // first word of each two-cycle sequence
  function automatic logic [FSC_DW-1:0] first_word(input fsc_op_e op);
    case (op)
      FSC_OP_LOCK:      first_word = FSC_CMD_LOCK_SETUP;
      FSC_OP_UNLOCK:    first_word = FSC_CMD_LOCK_SETUP;
      FSC_OP_PIN_CFG:   first_word = FSC_CMD_PIN_CFG;
      FSC_OP_OTP_PROG:  first_word = FSC_CMD_OTP_SETUP;
      FSC_OP_CLEAR_SR:  first_word = FSC_CMD_CLEAR_SR;
      default:          first_word = FSC_CMD_READ_ID;
    endcase
  endfunction : first_word

  always_comb begin
    st_next = st_reg;
    st_next.done = 1'b0;
    st_next.refused = 1'b0;
    st_next.evt = 1'b0;
    st_next.pin_d = i_status_output_pin;
    b_start = 1'b0;
    b_wr    = 1'b1;
    b_addr  = st_reg.addr;
    b_wdata = first_word(st_reg.op);
    // RULE2: erase completion edge
    // RULE3: program completion edge too
    if (st_reg.pin_mode != FSC_CFG_LEVEL && st_reg.pin_d && !i_status_output_pin) begin
      st_next.evt = 1'b1;
    end
    case (st_reg.state)
      S_IDLE: begin
        if (i_req) begin
          // RULE4: unsupported code never issued
          if (i_op == FSC_OP_PIN_CFG && i_pin_code == FSC_CFG_PRG_ONLY) begin
            st_next.refused = 1'b1;
          // RULE1: level pin high means ready
          // RULE14: lock ops refused while level pin shows busy; not checked in pulse modes
          // RULE24: config refused while level pin shows busy; not checked in pulse modes
          end else if ((i_op == FSC_OP_LOCK || i_op == FSC_OP_UNLOCK || i_op == FSC_OP_PIN_CFG)
                       && st_reg.pin_mode == FSC_CFG_LEVEL && !i_status_output_pin) begin
            st_next.refused = 1'b1;
          end else begin
            st_next.op     = i_op;
            st_next.addr   = i_addr;
            st_next.wdata  = i_wdata;
            st_next.busy   = 1'b1;
            st_next.issued = 1'b0;
            st_next.state  = S_W1;
          end
        end
      end
      S_W1: begin
        // RULE19: id mode entry before reads
        b_start = !st_reg.issued;
        st_next.issued = 1'b1;
        if (bus_if.done) begin
          st_next.issued = 1'b0;
          if (st_reg.op == FSC_OP_CLEAR_SR) begin
            // RULE16: errors dropped only by clear or reset
            st_next.status = '0;
            st_next.state  = S_FIN;
          end else if (st_reg.op == FSC_OP_READ_LOCK || st_reg.op == FSC_OP_OTP_READ) begin
            st_next.state = S_RD;
          end else begin
            st_next.state = S_W2;
          end
        end
      end
      S_W2: begin
        b_start = !st_reg.issued;
        case (st_reg.op)
          // RULE8: confirm inside target block
          FSC_OP_LOCK:     b_wdata = FSC_CMD_LOCK_SET;
          // RULE9: confirm clears all blocks
          FSC_OP_UNLOCK:   b_wdata = FSC_CMD_UNLOCK_ALL;
          // RULE7: reserved bits driven zero
          FSC_OP_PIN_CFG:  b_wdata = {8'h00, FSC_CFG_RSVD, i_pin_code};
          // RULE20: address and data latched
          // RULE23: lock word data given by user
          default:         b_wdata = st_reg.wdata;
        endcase
        st_next.issued = 1'b1;
        if (bus_if.done) begin
          st_next.issued = 1'b0;
          st_next.polls  = '0;
          if (st_reg.op == FSC_OP_PIN_CFG) begin
            st_next.pin_mode = i_pin_code;
            st_next.state    = S_EXIT;
          end else begin
            st_next.state = S_POLL;
          end
        end
      end
      S_RD: begin
        // RULE17: lock state at base plus 02h
        b_wr   = 1'b0;
        b_addr = (st_reg.op == FSC_OP_READ_LOCK) ? st_reg.addr + FSC_LOCK_STAT_OFS : st_reg.addr;
        b_start = !st_reg.issued;
        st_next.issued = 1'b1;
        if (bus_if.done) begin
          st_next.issued = 1'b0;
          st_next.rdata  = bus_if.rdata;
          st_next.state  = S_EXIT;
        end
      end
      S_POLL: begin
        // RULE12: reads already return status
        // RULE13: wait for ready flag
        b_wr   = 1'b0;
        b_start = !st_reg.issued;
        st_next.issued = 1'b1;
        if (bus_if.done) begin
          st_next.issued = 1'b0;
          st_next.polls  = st_reg.polls + 16'h0001;
          if (bus_if.rdata[FSC_SR_READY] || st_reg.polls == 16'(POLL_MAX - 1)) begin
            // RULE6: both flags kept sticky
            // RULE21: program error captured
            // RULE22: locked error captured
            st_next.status = st_reg.status | bus_if.rdata[7:0];
            st_next.rdata  = bus_if.rdata;
            st_next.err    = !bus_if.rdata[FSC_SR_READY]
                             || bus_if.rdata[FSC_SR_PROG_ERR]
                             || bus_if.rdata[FSC_SR_ERASE_ERR]
                             || bus_if.rdata[FSC_SR_LOCKED_ERR];
            st_next.state  = S_EXIT;
          end
        end
      end
      S_EXIT: begin
        // leave status/id mode so array reads work again
        b_wdata = FSC_CMD_READ_ARRAY;
        b_start = !st_reg.issued;
        st_next.issued = 1'b1;
        if (bus_if.done) begin
          st_next.issued = 1'b0;
          st_next.state  = S_FIN;
        end
      end
      S_FIN: begin
        st_next.busy  = 1'b0;
        st_next.done  = 1'b1;
        st_next.state = S_IDLE;
      end
      default: st_next.state = S_IDLE;
    endcase
  end

  // RULE10: lock bits live in the device
  // RULE11: refusal reported via status
  // RULE15: supply lockout shows as error
  // RULE18: array reached by address
  // RULE25: level mode after reset
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      st_reg          <= '0;
      st_reg.state    <= S_IDLE;
      st_reg.pin_mode <= FSC_CFG_LEVEL;
      st_reg.pin_d    <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_busy      = st_reg.busy;
  assign o_done      = st_reg.done;
  assign o_rdata     = st_reg.rdata;
  assign o_status    = st_reg.status;
  assign o_err       = st_reg.err;
  assign o_refused   = st_reg.refused;
  // RULE5: falling edge of pulse detected
  assign o_evt_pulse = st_reg.evt;
endmodule : fsc_ctrl

// File: verif/fsc_ctrl_asserts.sv
`timescale 1ns/1ps
// Purpose: port checks for the flash controller
// Assumes: one clock, synchronous reset
// Notes:   sees only fsc_ctrl ports; bound below
module fsc_ctrl_asserts #(
  parameter int POLL_MAX = 4096
) (
  input wire logic             i_core_clk,
  input wire logic             i_rst,
  input wire logic             i_req,
  input wire fsc_pkg::fsc_op_e i_op,
  input wire logic [1:0]       i_pin_code,
  input wire logic             o_busy,
  input wire logic             o_done,
  input wire logic [7:0]       o_status,
  input wire logic             o_err,
  input wire logic             o_refused,
  input wire logic             o_evt_pulse,
  input wire logic [15:0]      o_dq,
  input wire logic             o_dq_oe,
  input wire logic             o_ce_n,
  input wire logic             o_we_n,
  input wire logic             o_oe_n
);
  import fsc_pkg::*;
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  wire take = i_req && !o_busy;
  // each op opens with its setup word
  property first_write(fsc_op_e op, logic [15:0] cmd);
    (take && i_op == op) ##1 o_busy |-> ##[0:3] (!o_we_n && o_dq_oe && o_dq == cmd);
  endproperty
  AST_REQ_TAKEN: assert property (take |=> o_busy || o_refused)
    else $error("request neither taken nor refused");
  AST_BAD_CODE: assert property (take && i_op == FSC_OP_PIN_CFG && i_pin_code == FSC_CFG_PRG_ONLY |=> o_refused && !o_busy)
    else $error("code 10 not refused");
  AST_REFUSE_QUIET: assert property (o_refused |-> o_ce_n && o_we_n && !o_busy)
    else $error("bus touched on refusal");
  AST_LOCK_SETUP: assert property (first_write(FSC_OP_LOCK, FSC_CMD_LOCK_SETUP))
    else $error("lock setup word wrong");
  AST_UNLOCK_SETUP: assert property (first_write(FSC_OP_UNLOCK, FSC_CMD_LOCK_SETUP))
    else $error("unlock setup word wrong");
  AST_OTP_SETUP: assert property (first_write(FSC_OP_OTP_PROG, FSC_CMD_OTP_SETUP))
    else $error("otp setup word wrong");
  AST_PIN_SETUP: assert property (first_write(FSC_OP_PIN_CFG, FSC_CMD_PIN_CFG))
    else $error("pin config word wrong");
  AST_ID_SETUP: assert property (first_write(FSC_OP_READ_LOCK, FSC_CMD_READ_ID))
    else $error("id read word wrong");
  AST_ERR_HOLD: assert property (o_status[FSC_SR_PROG_ERR] && !o_busy && !o_done && !i_req |=> o_status[FSC_SR_PROG_ERR])
    else $error("error flag dropped between ops");
  AST_WRITE_DRIVE: assert property (!o_we_n |-> o_dq_oe && o_oe_n && !o_ce_n)
    else $error("write strobe without driven data");
  AST_WE_LEN: assert property ($fell(o_we_n) |-> (!o_we_n) [*8])
    else $error("write strobe too short");
  cover property (o_evt_pulse);
  cover property (o_refused);
  cover property (o_done && o_err);
endmodule : fsc_ctrl_asserts

bind fsc_ctrl fsc_ctrl_asserts #(.POLL_MAX(POLL_MAX)) fsc_ctrl_asserts_i (
  .i_core_clk, .i_rst, .i_req, .i_op, .i_pin_code,
  .o_busy, .o_done, .o_status, .o_err, .o_refused, .o_evt_pulse,
  .o_dq, .o_dq_oe, .o_ce_n, .o_we_n, .o_oe_n
);

// File: verif/fsc_flash_model.sv
`timescale 1ns/1ps
// Purpose: behavioural flash device
// Assumes: pins sampled on the core clock, no device reset pin
// Notes:   lock bits and otp words never reset; released bus toggles
module fsc_flash_model #(
  parameter int          BUSY_CYC  = 20,
  parameter int          PULSE_CYC = fsc_pkg::FSC_PULSE_CYC,
  parameter logic [15:0] UID_WORD  = 16'h0000
) (
  input  wire logic        i_core_clk,
  input  wire logic [23:0] i_addr,
  input  wire logic [15:0] i_dq,
  input  wire logic        i_ce_n,
  input  wire logic        i_we_n,
  input  wire logic        i_oe_n,
  input  wire logic        i_program_enable_supply_ok,
  input  wire logic        i_hold_busy,
  input  wire logic        i_erase_done,
  output logic [15:0]      o_dq,
  output logic             o_status_output_pin
);
  import fsc_pkg::*;
  // shipped unlocked, kept over controller reset
  logic [255:0] lk   = '0;
  logic [15:0]  otp [0:8];
  logic [7:0]   sr   = '0;
  logic [1:0]   cfg  = 2'h0;
  logic [1:0]   pend = 2'h0;
  logic [1:0]   mode = 2'h0;
  logic [23:0]  wa   = '0;
  logic [15:0]  wd   = '0;
  logic [15:0]  rd;
  logic [15:0]  dq_r = 16'h5A5A;
  logic         we_q = 1'b1;
  logic         prog = 1'b0;
  int           bcnt = 0;
  int           pcnt = 0;
  wire          busy = (bcnt != 0) || i_hold_busy;
  assign o_dq = dq_r;
  // level shows ready; pulse modes idle high
  assign o_status_output_pin = (cfg == 2'h0) ? ~busy : (pcnt == 0);
  // factory half fixed, user half blank
  initial begin
    otp[0] = 16'hFFFE;
    for (int i = 1; i < 9; i++) otp[i] = (i < 5) ? UID_WORD : 16'hFFFF;
  end
  always_comb begin
    rd = 16'hFFFF;
    if (mode == 2'h1) rd = {8'h00, ~busy, sr[6:0]};
    else if (mode == 2'h2 && i_addr[15:0] == 16'h0002) rd = {15'h0000, lk[i_addr[23:16]]};
    else if (mode == 2'h2 && i_addr >= 24'h80 && i_addr <= 24'h88) rd = otp[i_addr[3:0]];
  end
  always @(posedge i_core_clk) begin
    we_q <= i_we_n | i_ce_n;
    if (!i_we_n && !i_ce_n) begin
      wa <= i_addr;
      wd <= i_dq;
    end
    dq_r <= (!i_ce_n && !i_oe_n) ? rd : ~dq_r;
    bcnt <= (bcnt > 0) ? bcnt - 1 : 0;
    pcnt <= (pcnt > 0) ? pcnt - 1 : 0;
    // low pulse on completion, none for lock ops
    if ((bcnt == 1 && prog && cfg[1]) || (i_erase_done && cfg[0])) pcnt <= PULSE_CYC;
    if (!we_q && i_we_n) begin
      pend <= 2'h0;
      case (pend)
        2'h1: begin
          mode <= 2'h1;
          prog <= 1'b0;
          bcnt <= BUSY_CYC;
          // bits move only with valid supply
          if (wd == FSC_CMD_LOCK_SET && i_program_enable_supply_ok) lk[wa[23:16]] <= 1'b1;
          else if (wd == FSC_CMD_LOCK_SET) sr[4] <= 1'b1;
          else if (wd == FSC_CMD_UNLOCK_ALL && i_program_enable_supply_ok) lk <= '0;
          else sr[5] <= 1'b1;
        end
        2'h2: begin
          mode <= 2'h1;
          if (wa < 24'h80 || wa > 24'h88) sr[4] <= 1'b1;
          else if ((wa != 24'h80 && wa < 24'h85) || !otp[0][1]) {sr[4], sr[1]} <= 2'h3;
          else begin
            otp[wa[3:0]] <= otp[wa[3:0]] & wd;
            prog <= 1'b1;
            bcnt <= BUSY_CYC;
          end
        end
        // bad code flags both, upper bits ignored
        2'h3: if (wd[1:0] == 2'h2) sr[5:4] <= 2'h3; else cfg <= wd[1:0];
        default: begin
          // lock setup switches reads to status
          if (wd == FSC_CMD_LOCK_SETUP) {pend, mode} <= 4'h5;
          if (wd == FSC_CMD_OTP_SETUP) {pend, mode} <= 4'h9;
          if (wd == FSC_CMD_PIN_CFG) pend <= 2'h3;
          if (wd == FSC_CMD_READ_ID) mode <= 2'h2;
          if (wd == FSC_CMD_READ_ARRAY) mode <= 2'h0;
          if (wd == FSC_CMD_READ_SR) mode <= 2'h1;
          if (wd == FSC_CMD_CLEAR_SR) sr <= 8'h00;
        end
      endcase
    end
  end
endmodule : fsc_flash_model

// File: verif/test_fsc_ctrl.sv
`timescale 1ns/1ps
// Purpose: self-checking bench for fsc_ctrl
// Assumes: model busy 20 cycles, short poll limit
// Notes:   expectations from device rules
module test_fsc_ctrl;
  import fsc_pkg::*;
  localparam logic [15:0] UID = 16'h3C5A;  // arbitrary factory word
  logic        i_core_clk = 1'b0;
  logic        i_rst      = 1'b1;
  logic        i_req      = 1'b0;
  fsc_op_e     i_op       = FSC_OP_CLEAR_SR;
  logic [23:0] i_addr     = '0;
  logic [15:0] i_wdata    = '0;
  logic [1:0]  i_pin_code = '0;
  logic        program_enable_supply_ok = 1'b1, hold_busy = 1'b0, erase_done = 1'b0, was_refused;
  logic        i_status_output_pin, o_busy, o_done, o_err, o_refused, o_evt_pulse, o_dq_oe, o_ce_n, o_we_n, o_oe_n;
  logic [15:0] i_dq, o_rdata, o_dq;
  logic [23:0] o_addr;
  logic [7:0]  o_status;
  int          num_errors = 0, samples_checked = 0, cycles = 0, evt_cnt = 0;
  always #2 i_core_clk = ~i_core_clk;
  fsc_ctrl #(.POLL_MAX(8)) fsc_ctrl_i (
    .i_core_clk, .i_rst, .i_req, .i_op, .i_addr, .i_wdata, .i_pin_code, .i_status_output_pin, .i_dq,
    .o_busy, .o_done, .o_rdata, .o_status, .o_err, .o_refused, .o_evt_pulse,
    .o_addr, .o_dq, .o_dq_oe, .o_ce_n, .o_we_n, .o_oe_n
  );
  fsc_flash_model #(.UID_WORD(UID)) fsc_flash_model_i (
    .i_core_clk, .i_addr(o_addr), .i_dq(o_dq), .i_ce_n(o_ce_n), .i_we_n(o_we_n), .i_oe_n(o_oe_n),
    .i_program_enable_supply_ok(program_enable_supply_ok), .i_hold_busy(hold_busy), .i_erase_done(erase_done),
    .o_dq(i_dq), .o_status_output_pin(i_status_output_pin)
  );
  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : conclude
  // cycle ceiling cuts a hang short
  always @(posedge i_core_clk) begin
    cycles++;
    if (o_evt_pulse === 1'b1) evt_cnt++;
    if (cycles == 20000) begin
      num_errors++;
      $display("unexpected at %0t: timeout", $time);
      conclude();
    end
  end
  task automatic chk(input logic [15:0] got, logic [15:0] exp, string what);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic run_op(input fsc_op_e op, logic [23:0] a, logic [15:0] d, logic [1:0] code);
    int n;
    n = 0;
    @(posedge i_core_clk);
    i_req <= 1'b1;
    i_op <= op;
    i_addr <= a;
    i_wdata <= d;
    i_pin_code <= code;
    @(posedge i_core_clk);
    i_req <= 1'b0;
    do begin
      @(negedge i_core_clk);
      n++;
    end while (o_done !== 1'b1 && o_refused !== 1'b1 && n < 3000);
    was_refused = o_refused;
  endtask : run_op
  task automatic lock_of(input logic [23:0] a, logic exp, string what);
    run_op(FSC_OP_READ_LOCK, a, 16'h0000, 2'h0);
    chk({15'h0000, o_rdata[0]}, {15'h0000, exp}, what);
  endtask : lock_of
  task automatic wait_pulse(input logic erase);
    @(posedge i_core_clk);
    erase_done <= erase;
    @(posedge i_core_clk);
    erase_done <= 1'b0;
    repeat (FSC_PULSE_CYC + 20) @(posedge i_core_clk);
  endtask : wait_pulse
  initial begin
    repeat (4) @(posedge i_core_clk);
    i_rst <= 1'b0;
    lock_of(24'h030000, 1'b0, "shipped unlocked");
    run_op(FSC_OP_LOCK, 24'h031234, 16'h0000, 2'h0);
    chk({o_rdata[7], o_err, was_refused}, 3'h4, "lock ready, no error");
    lock_of(24'h030000, 1'b1, "block locked");
    lock_of(24'h040000, 1'b0, "other block untouched");
    @(posedge i_core_clk) i_rst <= 1'b1;
    repeat (2) @(posedge i_core_clk);
    i_rst <= 1'b0;
    lock_of(24'h030000, 1'b1, "lock kept over reset");
    $display("test lock_set done");
    @(posedge i_core_clk) program_enable_supply_ok <= 1'b0;
    run_op(FSC_OP_UNLOCK, 24'h000000, 16'h0000, 2'h0);
    chk({o_err, o_status[5]}, 2'h3, "unlock error");
    run_op(FSC_OP_LOCK, 24'h050000, 16'h0000, 2'h0);
    chk(o_status[5:4], 2'h3, "both errors held");
    lock_of(24'h030000, 1'b1, "bits frozen");
    run_op(FSC_OP_CLEAR_SR, 24'h000000, 16'h0000, 2'h0);
    chk({o_status[5:4], o_status[1]}, 3'h0, "errors cleared");
    @(posedge i_core_clk) program_enable_supply_ok <= 1'b1;
    run_op(FSC_OP_UNLOCK, 24'h7FFFFE, 16'h0000, 2'h0);
    lock_of(24'h030000, 1'b0, "unlock all");
    $display("test lock_errors done");
    @(posedge i_core_clk) hold_busy <= 1'b1;
    repeat (4) @(posedge i_core_clk);
    run_op(FSC_OP_LOCK, 24'h060000, 16'h0000, 2'h0);
    chk(was_refused, 1'b1, "lock while busy");
    run_op(FSC_OP_PIN_CFG, 24'h000000, 16'h0000, 2'h3);
    chk(was_refused, 1'b1, "config while busy");
    @(posedge i_core_clk) hold_busy <= 1'b0;
    repeat (4) @(posedge i_core_clk);
    run_op(FSC_OP_PIN_CFG, 24'h000000, 16'h0000, 2'h2);
    chk(was_refused, 1'b1, "code 10");
    $display("test refusals done");
    run_op(FSC_OP_PIN_CFG, 24'h000000, 16'h0000, 2'h1);
    run_op(FSC_OP_OTP_PROG, 24'h000085, 16'h1234, 2'h1);
    wait_pulse(1'b0);
    chk(evt_cnt, 0, "no pulse on program");
    wait_pulse(1'b1);
    chk(evt_cnt, 1, "erase pulse");
    run_op(FSC_OP_PIN_CFG, 24'h000000, 16'h0000, 2'h3);
    run_op(FSC_OP_OTP_PROG, 24'h000086, 16'h00F0, 2'h3);
    wait_pulse(1'b0);
    chk(evt_cnt, 2, "program pulse");
    wait_pulse(1'b1);
    chk(evt_cnt, 3, "one event per pulse");
    run_op(FSC_OP_PIN_CFG, 24'h000000, 16'h0000, 2'h0);
    $display("test pin_modes done");
    run_op(FSC_OP_OTP_READ, 24'h000085, 16'h0000, 2'h0);
    chk(o_rdata, 16'h1234, "user word");
    run_op(FSC_OP_OTP_READ, 24'h000081, 16'h0000, 2'h0);
    chk(o_rdata, UID, "factory word");
    run_op(FSC_OP_OTP_PROG, 24'h000090, 16'h0000, 2'h0);
    chk({o_err, o_status[4]}, 2'h3, "out of range");
    run_op(FSC_OP_CLEAR_SR, 24'h000000, 16'h0000, 2'h0);
    run_op(FSC_OP_OTP_PROG, 24'h000081, 16'h0000, 2'h0);
    chk({o_status[4], o_status[1]}, 2'h3, "factory half locked");
    run_op(FSC_OP_CLEAR_SR, 24'h000000, 16'h0000, 2'h0);
    run_op(FSC_OP_OTP_PROG, FSC_OTP_LOCK_ADDR, FSC_OTP_LOCK_DATA, 2'h0);
    run_op(FSC_OP_OTP_READ, FSC_OTP_LOCK_ADDR, 16'h0000, 2'h0);
    chk(o_rdata, 16'hFFFC, "lock word");
    run_op(FSC_OP_OTP_PROG, 24'h000087, 16'h0000, 2'h0);
    chk({o_status[4], o_status[1]}, 2'h3, "user half locked");
    run_op(FSC_OP_OTP_READ, 24'h000087, 16'h0000, 2'h0);
    chk(o_rdata, 16'hFFFF, "word unchanged");
    $display("test otp done");
    conclude();
  end
endmodule : test_fsc_ctrl
